/* fasp_cmd.sv */
/*
  fasp_cmd: serial flash command decoder for protection configuration, lock
  register, secret password and gang volatile sector lock commands.
  assumes: chip select, serial clock and io pins come from the host
  asynchronously and are sampled on clk_in; serial clock well below clk_in/4;
  four-line mode level comes from logic on clk_in.
*/
`timescale 1ns/100ps
`default_nettype none

module fasp_cmd #(
  parameter int SECTORS = fasp_pkg::SECTOR_COUNT,
  parameter int BUSY    = fasp_pkg::BUSY_CYCLES
) (
  // clock and reset
  input  wire logic               clk_in,
  input  wire logic               rst_in,
  // serial pins
  input  wire logic               cs_n_in,
  input  wire logic               sck_in,
  input  wire logic [3:0]         io_in,
  output logic      [3:0]         io_out,
  output logic      [3:0]         io_oe_out,
  // mode
  input  wire logic               four_line_command_mode_in,
  // state
  output logic                    write_in_progress_flag_out,
  output logic                    write_enable_latch_out,
  output logic      [15:0]        protection_config_out,
  output logic      [7:0]         lock_control_out,
  output logic      [SECTORS-1:0] volatile_sector_lock_bits_out
);

  // ------------------------------------------------------------------
  // byte order helper
  // ------------------------------------------------------------------
  function automatic logic [63:0] fasp_bswap(input logic [63:0] v);
    logic [63:0] r;
    r = 64'h0;
    for (int i = 0; i < 8; i++) begin
      r[8*i +: 8] = v[56-8*i +: 8];
    end
    return r;
  endfunction

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  fasp_pkg::fasp_pins_t sync1_r;
  fasp_pkg::fasp_pins_t sync2_r;
  fasp_pkg::fasp_pins_t sync3_r;
  fasp_pkg::fasp_pins_t pins_now;

  always_comb begin
    pins_now.cs_n = cs_n_in;
    pins_now.sck  = sck_in;
    pins_now.io   = io_in;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sync1_r <= '{cs_n: 1'b1, sck: 1'b0, io: 4'h0};
      sync2_r <= '{cs_n: 1'b1, sck: 1'b0, io: 4'h0};
      sync3_r <= '{cs_n: 1'b1, sck: 1'b0, io: 4'h0};
    end else begin
      sync1_r <= pins_now;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  logic sck_rise;
  logic sck_fall;
  logic cs_rise;

  always_comb begin
    sck_rise = sync2_r.sck & ~sync3_r.sck & ~sync2_r.cs_n;
    sck_fall = ~sync2_r.sck & sync3_r.sck & ~sync2_r.cs_n;
    cs_rise  = sync2_r.cs_n & ~sync3_r.cs_n;
  end

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  fasp_pkg::fasp_state_t state_r, state_nxt;
  logic [6:0]          cnt_r, cnt_nxt;
  logic [7:0]          op_r, op_nxt;
  logic [63:0]         sh_r, sh_nxt;
  logic [63:0]         tx_r, tx_nxt;
  logic                rd_r, rd_nxt;
  logic [7:0]          pend_r, pend_nxt;
  logic [63:0]         pdata_r, pdata_nxt;
  logic [15:0]         busy_r, busy_nxt;
  logic [15:0]         cfg_r, cfg_nxt;
  logic [7:0]          lock_r, lock_nxt;
  logic [63:0]         pwd_r, pwd_nxt;
  logic [SECTORS-1:0]  dyb_r, dyb_nxt;
  logic                wel_r, wel_nxt;
  logic [3:0]          io_r, io_nxt;
  logic [3:0]          oe_r, oe_nxt;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  logic       quad;
  logic       secret_mode;
  logic [6:0] step;
  logic [6:0] cnt_add;
  logic [7:0] op_full;
  logic       start;

  always_comb begin
    quad        = four_line_command_mode_in;
    secret_mode = ~cfg_r[fasp_pkg::CFG_SECRET_MODE_BIT];
    step        = quad ? 7'h04 : 7'h01;
    cnt_add     = (cnt_r > fasp_pkg::BITS_MAX - step) ? fasp_pkg::BITS_MAX : cnt_r + step;
    op_full     = quad ? {op_r[3:0], sync2_r.io} : {op_r[6:0], sync2_r.io[0]};
    start       = 1'b0;
    state_nxt   = state_r;
    cnt_nxt     = cnt_r;
    op_nxt      = op_r;
    sh_nxt      = sh_r;
    tx_nxt      = tx_r;
    rd_nxt      = rd_r;
    pend_nxt    = pend_r;
    pdata_nxt   = pdata_r;
    busy_nxt    = busy_r;
    cfg_nxt     = cfg_r;
    lock_nxt    = lock_r;
    pwd_nxt     = pwd_r;
    dyb_nxt     = dyb_r;
    wel_nxt     = wel_r;
    io_nxt      = io_r;
    oe_nxt      = oe_r;

    // shift in on serial clock rise
    if (sck_rise) begin
      cnt_nxt = cnt_add;
      if (cnt_r < fasp_pkg::BITS_OPCODE) begin
        op_nxt = op_full;
        if (cnt_add == fasp_pkg::BITS_OPCODE) begin
          unique case (op_full)
            fasp_pkg::OP_READ_PROTECTION_CONFIG: begin
              rd_nxt = 1'b1;
              tx_nxt = {4{cfg_r[7:0], cfg_r[15:8]}};
            end
            fasp_pkg::OP_READ_LOCK_REGISTER: begin
              rd_nxt = ~quad;
              tx_nxt = {8{lock_r}};
            end
            fasp_pkg::OP_READ_SECRET: begin
              rd_nxt = ~quad & ~secret_mode;
              tx_nxt = fasp_bswap(pwd_r);
            end
            default: rd_nxt = 1'b0;
          endcase
        end
      end else if (quad) begin
        sh_nxt = {sh_r[59:0], sync2_r.io};
      end else begin
        sh_nxt = {sh_r[62:0], sync2_r.io[0]};
      end
    end

    // drive read data on serial clock fall, rotating so the value repeats
    if (sck_fall && rd_r) begin
      if (quad) begin
        io_nxt = tx_r[63:60];
        oe_nxt = 4'hf;
        tx_nxt = {tx_r[59:0], tx_r[63:60]};
      end else begin
        io_nxt = {2'b00, tx_r[63], 1'b0};
        oe_nxt = 4'h2;
        tx_nxt = {tx_r[62:0], tx_r[63]};
      end
    end

    // end of frame
    if (sync2_r.cs_n) begin
      cnt_nxt = 7'h00;
      rd_nxt  = 1'b0;
      oe_nxt  = 4'h0;
    end

    // command execution on chip select rise
    if (cs_rise && state_r == fasp_pkg::ST_IDLE) begin
      unique case (op_r)
        fasp_pkg::OP_WRITE_ENABLE: begin
          if (cnt_r == fasp_pkg::BITS_OPCODE) begin
            wel_nxt = 1'b1;
          end
        end
        fasp_pkg::OP_PROGRAM_PROTECTION_CONFIG: begin
          start     = wel_r && cnt_r == fasp_pkg::BITS_CFG_PROG;
          pdata_nxt = {48'h0, sh_r[7:0], sh_r[15:8]};
        end
        fasp_pkg::OP_CLEAR_LOCK_BIT: begin
          start = wel_r && !secret_mode && cnt_r == fasp_pkg::BITS_OPCODE;
        end
        fasp_pkg::OP_SET_CONFIG_FREEZE: begin
          start = wel_r && cnt_r == fasp_pkg::BITS_OPCODE;
        end
        fasp_pkg::OP_PROGRAM_SECRET: begin
          start     = wel_r && !secret_mode && cnt_r == fasp_pkg::BITS_SECRET;
          pdata_nxt = fasp_bswap(sh_r);
        end
        fasp_pkg::OP_SECRET_UNLOCK: begin
          start     = cnt_r == fasp_pkg::BITS_SECRET;
          pdata_nxt = fasp_bswap(sh_r);
        end
        fasp_pkg::OP_GANG_LOCK, fasp_pkg::OP_GANG_UNLOCK: begin
          start = wel_r && cnt_r != 7'h00 && cnt_r[2:0] == 3'h0;
        end
        default: start = 1'b0;
      endcase
      if (start) begin
        state_nxt = fasp_pkg::ST_BUSY;
        pend_nxt  = op_r;
        busy_nxt  = 16'(BUSY - 1);
      end
    end

    // internal operation; effects land at completion
    if (state_r == fasp_pkg::ST_BUSY) begin
      if (busy_r != 16'h0000) begin
        busy_nxt = busy_r - 16'h0001;
      end else begin
        state_nxt = fasp_pkg::ST_IDLE;
        unique case (pend_r)
          fasp_pkg::OP_PROGRAM_PROTECTION_CONFIG: begin
            cfg_nxt = pdata_r[15:0];
            wel_nxt = 1'b0;
          end
          fasp_pkg::OP_CLEAR_LOCK_BIT: begin
            lock_nxt[fasp_pkg::LOCK_BIT] = 1'b0;
            wel_nxt                      = 1'b0;
          end
          fasp_pkg::OP_SET_CONFIG_FREEZE: begin
            lock_nxt[fasp_pkg::FREEZE_BIT] = 1'b1;
            wel_nxt                        = 1'b0;
          end
          fasp_pkg::OP_PROGRAM_SECRET: begin
            pwd_nxt = pdata_r;
            wel_nxt = 1'b0;
          end
          fasp_pkg::OP_SECRET_UNLOCK: begin
            if (pdata_r == pwd_r) begin
              lock_nxt[fasp_pkg::LOCK_BIT] = 1'b1;
            end
          end
          fasp_pkg::OP_GANG_LOCK: begin
            dyb_nxt = '0;
          end
          fasp_pkg::OP_GANG_UNLOCK: begin
            dyb_nxt = '1;
          end
          default: pend_nxt = pend_r;
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_r <= fasp_pkg::ST_IDLE;
      cnt_r   <= 7'h00;
      op_r    <= 8'h00;
      sh_r    <= 64'h0;
      tx_r    <= 64'h0;
      rd_r    <= 1'b0;
      pend_r  <= 8'h00;
      pdata_r <= 64'h0;
      busy_r  <= 16'h0000;
      cfg_r   <= fasp_pkg::CFG_RESET;
      lock_r  <= fasp_pkg::LOCK_RESET;
      pwd_r   <= fasp_pkg::SECRET_RESET;
      dyb_r   <= '1;
      wel_r   <= 1'b0;
      io_r    <= 4'h0;
      oe_r    <= 4'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      op_r    <= op_nxt;
      sh_r    <= sh_nxt;
      tx_r    <= tx_nxt;
      rd_r    <= rd_nxt;
      pend_r  <= pend_nxt;
      pdata_r <= pdata_nxt;
      busy_r  <= busy_nxt;
      cfg_r   <= cfg_nxt;
      lock_r  <= lock_nxt;
      pwd_r   <= pwd_nxt;
      dyb_r   <= dyb_nxt;
      wel_r   <= wel_nxt;
      io_r    <= io_nxt;
      oe_r    <= oe_nxt;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  always_comb begin
    io_out                        = io_r;
    io_oe_out                     = oe_r;
    write_in_progress_flag_out    = state_r[1];
    write_enable_latch_out        = wel_r;
    protection_config_out         = cfg_r;
    lock_control_out              = lock_r;
    volatile_sector_lock_bits_out = dyb_r;
  end

endmodule // fasp_cmd

`default_nettype wire

/* fasp_cmd_assertions.sv */
/* fasp_cmd_assertions: port checks for fasp_cmd.
   assumes: bound to fasp_cmd; one clock, synchronous active high reset. */
`timescale 1ns/100ps
`default_nettype none
module fasp_cmd_assertions #(
  parameter int SECTORS = 128,
  parameter int BUSY    = 16
) (
  // clock and reset
  input wire logic               clk_in,
  input wire logic               rst_in,
  // pins
  input wire logic               cs_n_in,
  input wire logic               sck_in,
  input wire logic [3:0]         io_in,
  input wire logic [3:0]         io_out,
  input wire logic [3:0]         io_oe_out,
  input wire logic               four_line_command_mode_in,
  // state
  input wire logic               write_in_progress_flag_out,
  input wire logic               write_enable_latch_out,
  input wire logic [15:0]        protection_config_out,
  input wire logic [7:0]         lock_control_out,
  input wire logic [SECTORS-1:0] volatile_sector_lock_bits_out
);
  // ------------------------------------------------------------------
  // busy length counter
  // ------------------------------------------------------------------
  logic [7:0] busy_cnt_r;
  logic [7:0] busy_cnt_nxt;
  always_comb busy_cnt_nxt = write_in_progress_flag_out ? busy_cnt_r + 8'h01 : 8'h00;
  always_ff @(posedge clk_in) busy_cnt_r <= rst_in ? 8'h00 : busy_cnt_nxt;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_busy_end;
    $fell(write_in_progress_flag_out);
  endsequence
  sequence s_cs_idle;
    cs_n_in [*6];
  endsequence

  chk_busy_len: assert property (
    s_busy_end |-> busy_cnt_r == 8'(BUSY)) else $error("busy length wrong");
  chk_busy_start: assert property (
    $rose(write_in_progress_flag_out) |-> $past(cs_n_in) && $past(cs_n_in, 3))
    else $error("busy without select release");
  chk_wel_drop: assert property (
    $fell(write_enable_latch_out) |-> s_busy_end) else $error("latch dropped early");
  chk_wel_set: assert property (
    $rose(write_enable_latch_out) |-> $past(cs_n_in)) else $error("latch set in frame");
  chk_cfg_when: assert property (
    !$stable(protection_config_out) |-> s_busy_end) else $error("config moved early");
  chk_lock_when: assert property (
    !$stable(lock_control_out) |-> s_busy_end) else $error("lock moved early");
  chk_vol_when: assert property (
    !$stable(volatile_sector_lock_bits_out) |-> s_busy_end) else $error("sector bits early");
  chk_freeze_hold: assert property (
    !$fell(lock_control_out[7])) else $error("freeze bit cleared");
  chk_oe_release: assert property (
    s_cs_idle |-> io_oe_out == 4'h0) else $error("drive while deselected");
  chk_oe_single: assert property (
    io_oe_out == 4'h2 |-> !four_line_command_mode_in) else $error("single read in quad");
endmodule // fasp_cmd_assertions

bind fasp_cmd fasp_cmd_assertions #(.SECTORS(SECTORS), .BUSY(BUSY)) u_chk (
  .clk_in(clk_in), .rst_in(rst_in), .cs_n_in(cs_n_in), .sck_in(sck_in),
  .io_in(io_in), .io_out(io_out), .io_oe_out(io_oe_out),
  .four_line_command_mode_in(four_line_command_mode_in),
  .write_in_progress_flag_out(write_in_progress_flag_out),
  .write_enable_latch_out(write_enable_latch_out),
  .protection_config_out(protection_config_out), .lock_control_out(lock_control_out),
  .volatile_sector_lock_bits_out(volatile_sector_lock_bits_out));
`default_nettype wire

/* fasp_host.sv */
/* fasp_host: host controller model framing commands on the serial pins.
   assumes: bench resolves io levels from both drivers; 80 ns serial clock. */
`timescale 1ns/100ps
`default_nettype none
module fasp_host (
  // serial pins
  output logic       cs_n_out,
  output logic       sck_out,
  output logic [3:0] io_out,
  // returned data and status
  input  wire logic  so_in,
  input  wire logic  wip_in
);
  initial begin
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    io_out = 4'h0;
  end
  // one frame: d left aligned, n clocks, quad sends a nibble a clock
  task automatic xfer(input logic [71:0] d, input int n, input bit quad,
                      output logic [63:0] q);
    q = 64'h0;
    wait (!wip_in);
    cs_n_out = 1'b0;
    for (int i = 0; i < n; i++) begin
      io_out = quad ? d[71-4*i -: 4] : {3'h0, (i < 72) ? d[71-i] : i[0]};
      #40 sck_out = 1'b1;
      #20 q = {q[62:0], so_in};
      #20 sck_out = 1'b0;
    end
    #40 cs_n_out = 1'b1;
    #80;
  endtask
endmodule // fasp_host
`default_nettype wire

/* fasp_pkg.sv */
/*
  fasp_pkg: shared constants and types for the flash protection command block.
  assumes: used with fasp_cmd; nothing imported, every use is scoped.
*/
`default_nettype none

package fasp_pkg;

  // ------------------------------------------------------------------
  // opcodes
  // ------------------------------------------------------------------
  localparam logic [7:0] OP_READ_PROTECTION_CONFIG    = 8'h2b;
  localparam logic [7:0] OP_PROGRAM_PROTECTION_CONFIG = 8'h2f;
  localparam logic [7:0] OP_READ_LOCK_REGISTER        = 8'ha7;
  localparam logic [7:0] OP_CLEAR_LOCK_BIT            = 8'ha6;
  localparam logic [7:0] OP_SET_CONFIG_FREEZE         = 8'h91;
  localparam logic [7:0] OP_READ_SECRET               = 8'he7;
  localparam logic [7:0] OP_PROGRAM_SECRET            = 8'he8;
  localparam logic [7:0] OP_SECRET_UNLOCK             = 8'he9;
  localparam logic [7:0] OP_GANG_LOCK                 = 8'h7e;
  localparam logic [7:0] OP_GANG_UNLOCK               = 8'h98;
  localparam logic [7:0] OP_WRITE_ENABLE              = 8'h06;

  // ------------------------------------------------------------------
  // bit counts of each frame and the count ceiling BITS_MAX, in serial bits after chip select falls
  // ------------------------------------------------------------------
  localparam logic [6:0] BITS_OPCODE   = 7'h08;
  localparam logic [6:0] BITS_CFG_PROG = 7'h18;
  localparam logic [6:0] BITS_SECRET   = 7'h48;
  localparam logic [6:0] BITS_MAX      = 7'h7f;

  // ------------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------------
  localparam int          CFG_SECRET_MODE_BIT = 2;
  localparam int          LOCK_BIT            = 0;
  localparam int          FREEZE_BIT          = 7;
  localparam logic [15:0] CFG_RESET           = 16'hffff;
  localparam logic [63:0] SECRET_RESET        = 64'hffff_ffff_ffff_ffff;
  localparam logic [7:0]  LOCK_RESET          = {7'h00, CFG_RESET[CFG_SECRET_MODE_BIT]};

  // ------------------------------------------------------------------
  // timing and sizes
  // ------------------------------------------------------------------
  localparam int          BUSY_CYCLES   = 16;
  localparam int          SECTOR_COUNT  = 128;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic       cs_n;
    logic       sck;
    logic [3:0] io;
  } fasp_pins_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } fasp_state_t;

endpackage

`default_nettype wire

/* tb.sv */
/* tb: self-checking bench for fasp_cmd.
   assumes: fasp_host drives the pins; 100 MHz clock. */
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int BUSY = 16;
  logic         clk_in;
  logic         rst_in;
  logic         quad;
  logic         cs_n;
  logic         sck;
  logic         write_in_progress_flag;
  logic         write_enable_latch;
  logic [3:0]   io_w;
  logic [3:0]   dut_io;
  logic [3:0]   dut_oe;
  logic [3:0]   host_io;
  logic [15:0]  cfg;
  logic [7:0]   lock;
  logic [127:0] vol;
  logic [63:0]  q;
  int           n_fail = 0;
  int           checked = 0;
  int           cyc = 0;
  localparam logic [63:0] PW = 64'hefcdab8967452301;

  assign io_w = (dut_oe & dut_io) | (~dut_oe & host_io);
  fasp_host host (.cs_n_out(cs_n), .sck_out(sck), .io_out(host_io), .so_in(io_w[1]),
                  .wip_in(write_in_progress_flag));
  fasp_cmd #(.SECTORS(128), .BUSY(BUSY)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .cs_n_in(cs_n), .sck_in(sck), .io_in(io_w),
    .io_out(dut_io), .io_oe_out(dut_oe), .four_line_command_mode_in(quad),
    .write_in_progress_flag_out(write_in_progress_flag), .write_enable_latch_out(write_enable_latch),
    .protection_config_out(cfg), .lock_control_out(lock),
    .volatile_sector_lock_bits_out(vol));

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic op(input logic [7:0] o, input logic [63:0] d, input int n, input bit qd);
    quad = qd;
    host.xfer({o, d}, n, qd, q);
    repeat (BUSY + 10) @(negedge clk_in);
  endtask
  task automatic write_enable_command();
    op(fasp_pkg::OP_WRITE_ENABLE, 64'h0, 8, 1'b0);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    chk("cfg", cfg, 16'hffff);
    chk("lock", lock, 8'h01);
    chk("wel", write_enable_latch, 1'b0);
    chk("wip", write_in_progress_flag, 1'b0);
    chk("vol", vol, {128{1'b1}});
  endtask
  task automatic t_cfg();
    op(8'h2f, {16'h3c5a, 48'h0}, 24, 1'b0);
    chk("cfg", cfg, 16'hffff);
    write_enable_command();
    chk("wel", write_enable_latch, 1'b1);
    op(8'h2f, {16'h3c5a, 48'h0}, 25, 1'b0);
    chk("cfg", cfg, 16'hffff);
    op(8'h2f, {16'h3c5a, 48'h0}, 24, 1'b0);
    chk("cfg", cfg, 16'h5a3c);
    chk("wel", write_enable_latch, 1'b0);
    op(8'h2b, 64'h0, 40, 1'b0);
    chk("cfg rd", q[31:0], 32'h3c5a3c5a);
    op(8'h2b, 64'h0, 10, 1'b1);
    chk("cfg quad", q[7:0], 8'h99);
  endtask
  task automatic t_lock();
    op(8'ha7, 64'h0, 24, 1'b0);
    chk("lock rd", q[15:0], 16'h0101);
    op(8'ha7, {64{1'b1}}, 6, 1'b1);
    chk("quad rd", q[5:0], 6'h3f);
    write_enable_command();
    op(8'ha6, 64'h0, 16, 1'b0);
    chk("lock", lock, 8'h01);
    op(8'ha6, 64'h0, 8, 1'b0);
    chk("lock", lock, 8'h00);
    chk("wel", write_enable_latch, 1'b0);
    write_enable_command();
    host.xfer({8'h91, 64'h0}, 8, 1'b0, q);
    chk("wip", write_in_progress_flag, 1'b1);
    repeat (BUSY + 10) @(negedge clk_in);
    chk("lock", lock, 8'h80);
  endtask
  task automatic t_secret();
    write_enable_command();
    op(8'he8, PW, 72, 1'b0);
    chk("wel", write_enable_latch, 1'b0);
    op(8'he7, 64'h0, 72, 1'b0);
    chk("pw rd", q, PW);
    op(8'he9, PW ^ 64'h1, 72, 1'b0);
    chk("lock", lock, 8'h80);
    op(8'he9, PW, 71, 1'b0);
    chk("lock", lock, 8'h80);
    write_enable_command();
    op(8'h2f, {16'h3858, 48'h0}, 24, 1'b0);
    chk("cfg", cfg, 16'h5838);
    op(8'he9, PW, 72, 1'b0);
    chk("lock", lock, 8'h81);
    op(8'he7, 64'h0, 72, 1'b0);
    chk("pw rd", q, 64'h0);
    write_enable_command();
    op(8'he8, 64'h0, 72, 1'b0);
    chk("wel", write_enable_latch, 1'b1);
  endtask
  task automatic t_gang();
    op(8'h7e, 64'h0, 12, 1'b0);
    chk("vol", vol, {128{1'b1}});
    op(8'h7e, 64'h0, 2, 1'b1);
    chk("vol", vol, 128'h0);
    op(8'h98, 64'h0, 16, 1'b0);
    chk("vol", vol, {128{1'b1}});
  endtask

  // ------------------------------------------------------------------
  // clock, watchdog, sequence
  // ------------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      test_done();
    end
  end
  initial begin
    rst_in = 1'b1;
    quad = 1'b0;
    repeat (10) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (5) @(negedge clk_in);
    t_reset();
    t_cfg();
    t_lock();
    t_secret();
    t_gang();
    test_done();
  end
endmodule // tb
`default_nettype wire
